// ===== rtl/i2t_map.svh
`ifndef I2T_MAP_SVH
`define I2T_MAP_SVH

// System clock period and host-ready delay after reset.
`define I2T_CLK_PERIOD_NS 50
`define I2T_READY_NS 1000
`define I2T_READY_CYC ((`I2T_READY_NS + `I2T_CLK_PERIOD_NS - 1) / `I2T_CLK_PERIOD_NS)

// Register window reachable over the serial link.
`define I2T_REG_LAST 8'h1f
`define I2T_RX_HOLD_ADDR 8'h00

// Bit slots within a byte frame.
`define I2T_BITS_PER_BYTE 4'h8
`define I2T_LAST_TX_BIT 4'h7

// Filtered pin vector positions.
`define I2T_PIN_SCL 0
`define I2T_PIN_SDA 1
`define I2T_PIN_ALO 2
`define I2T_PIN_AHI 3

`endif

// ===== rtl/i2t_pin_filter.sv
`timescale 1ns/10ps
module i2t_pin_filter #(
  parameter int W = 4,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);
  import i2t_pkg::*;

  logic [W-1:0] ff1_r;
  logic [W-1:0] ff2_r;
  logic [W-1:0] ff3_r;

  // A level is accepted only once two settled stages agree, which also rejects one-cycle glitches.
  for (genvar g = 0; g < W; g++) begin : g_bit
    always_ff @(posedge i_clk_sys) begin
      if (i_rst) begin
        ff1_r[g] <= RST_VAL[g];
        ff2_r[g] <= RST_VAL[g];
        ff3_r[g] <= RST_VAL[g];
        o_level[g] <= RST_VAL[g];
      end else begin
        ff1_r[g] <= i_pin[g];
        ff2_r[g] <= ff1_r[g];
        ff3_r[g] <= ff2_r[g];
        if (ff2_r[g] == ff3_r[g]) begin
          o_level[g] <= ff3_r[g];
        end
      end
    end
  end

endmodule : i2t_pin_filter

// ===== rtl/i2t_pkg.sv
package i2t_pkg;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_RXB  = 5'b00010,
    ST_ACK  = 5'b00100,
    ST_TXB  = 5'b01000,
    ST_MACK = 5'b10000
  } i2t_state_t;

  typedef enum logic [1:0] {
    PH_ID    = 2'h0,
    PH_REG   = 2'h1,
    PH_WDATA = 2'h2
  } i2t_phase_t;

  typedef struct packed {
    logic req;
    logic [7:0] addr;
  } i2t_rd_req_t;

endpackage : i2t_pkg

// ===== rtl/i2t_target.sv
// What this block does
// - Acknowledge own identifier in following slot.
// - Acknowledge valid register byte, otherwise not-acknowledge.
// - Send eight register bits, MSB first.
// - Supply another byte after each host acknowledge.
// - ACK: line low across ninth clock high.
// - NACK: line released across ninth clock pulse.
// - Pull interrupt line low once reset finished.
// - Identifier: five fixed bits plus select pins.
// - Data changes with clock high mean START/STOP.
`timescale 1ns/10ps
`include "i2t_map.svh"
module i2t_target #(
  // Upper identifier bits; the value is arbitrary.
  parameter logic [4:0] TGT_ID_HI = 5'h0c
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_addr_select_hi_pin,
  input wire logic i_addr_select_lo_pin,
  output i2t_pkg::i2t_rd_req_t o_rd,
  input wire logic [7:0] i_rd_data,
  input wire logic i_uart_irq,
  output logic o_irq_n_o,
  output logic o_irq_n_oe
);
  import i2t_pkg::*;

  localparam int READY_LO = `I2T_READY_CYC;
  localparam int READY_HI = `I2T_READY_CYC + 2;

  logic [3:0] pin_q;
  logic scl_q;
  logic sda_q;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;
  i2t_state_t st_r;
  i2t_phase_t phase_r;
  logic [3:0] cnt_r;
  logic [7:0] rx_sh_r;
  logic [7:0] tx_sh_r;
  logic [7:0] ptr_r;
  logic ack_r;
  logic go_tx_r;
  logic m_ack_r;
  logic sda_oe_r;
  logic id_match;
  logic reg_valid;
  logic ack_now;
  logic byte_done;
  logic fetch_go;
  logic load_r;
  logic [7:0] ready_cnt_r;
  logic ready_r;
  logic irq_oe_r;

  i2t_pin_filter #(
    .W(4),
    .RST_VAL(4'h3)
  ) u_pin_filter (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .i_pin({i_addr_select_hi_pin, i_addr_select_lo_pin, i_sda, i_scl}),
    .o_level(pin_q)
  );

  assign scl_q = pin_q[`I2T_PIN_SCL];
  assign sda_q = pin_q[`I2T_PIN_SDA];

  ////////////////////////////////////////////////////////////////////////////////
  // Bus edge and condition detection.

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_q;
      sda_d_r <= sda_q;
    end
  end

  assign scl_rise = scl_q & ~scl_d_r;
  assign scl_fall = ~scl_q & scl_d_r;
  assign bus_start = scl_q & scl_d_r & sda_d_r & ~sda_q;
  assign bus_stop = scl_q & scl_d_r & ~sda_d_r & sda_q;

  // The last bit was shifted in on the eighth rise; this fall opens the ninth slot.
  assign byte_done = (st_r == ST_RXB) & scl_fall & (cnt_r == `I2T_BITS_PER_BYTE);
  assign id_match = (rx_sh_r[7:1] == {TGT_ID_HI, pin_q[`I2T_PIN_AHI], pin_q[`I2T_PIN_ALO]});
  assign reg_valid = (rx_sh_r <= `I2T_REG_LAST);

  always_comb begin
    ack_now = 1'b0;
    case (phase_r)
      PH_ID: ack_now = id_match;
      PH_REG: ack_now = reg_valid;
      default: ack_now = 1'b0;
    endcase
  end

  // Reads are fetched when the read identifier is taken and on every host acknowledge.
  assign fetch_go = (byte_done & (phase_r == PH_ID) & id_match & rx_sh_r[0])
      | ((st_r == ST_MACK) & scl_rise & ~sda_q);

  ////////////////////////////////////////////////////////////////////////////////
  // Frame sequencer and data line drive.

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      st_r <= ST_IDLE;
      phase_r <= PH_ID;
      cnt_r <= 4'h0;
      rx_sh_r <= 8'h00;
      ptr_r <= 8'h00;
      ack_r <= 1'b0;
      go_tx_r <= 1'b0;
      m_ack_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else if (bus_start) begin
      // A repeated START restarts identifier reception from any state.
      st_r <= ST_RXB;
      phase_r <= PH_ID;
      cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (bus_stop) begin
      st_r <= ST_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      if (fetch_go) begin
        ptr_r <= (ptr_r == `I2T_RX_HOLD_ADDR) ? ptr_r : ptr_r + 8'h01;
      end
      case (st_r)
        ST_IDLE: begin
          sda_oe_r <= 1'b0;
        end
        ST_RXB: begin
          if (scl_rise) begin
            rx_sh_r <= {rx_sh_r[6:0], sda_q};
            cnt_r <= cnt_r + 4'h1;
          end
          if (byte_done) begin
            st_r <= ST_ACK;
            ack_r <= ack_now;
            sda_oe_r <= ack_now;
            go_tx_r <= (phase_r == PH_ID) & rx_sh_r[0];
            if ((phase_r == PH_REG) & reg_valid) begin
              ptr_r <= rx_sh_r;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            if (!ack_r) begin
              st_r <= ST_IDLE;
              sda_oe_r <= 1'b0;
            end else if (go_tx_r) begin
              st_r <= ST_TXB;
              sda_oe_r <= ~tx_sh_r[7];
            end else begin
              st_r <= ST_RXB;
              phase_r <= (phase_r == PH_ID) ? PH_REG : PH_WDATA;
              sda_oe_r <= 1'b0;
            end
          end
        end
        ST_TXB: begin
          if (scl_fall) begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == `I2T_LAST_TX_BIT) begin
              st_r <= ST_MACK;
              sda_oe_r <= 1'b0;
            end else begin
              sda_oe_r <= ~tx_sh_r[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            m_ack_r <= ~sda_q;
          end
          if (scl_fall) begin
            cnt_r <= 4'h0;
            if (m_ack_r) begin
              st_r <= ST_TXB;
              sda_oe_r <= ~tx_sh_r[7];
            end else begin
              st_r <= ST_IDLE;
              sda_oe_r <= 1'b0;
            end
          end
        end
        default: begin
          st_r <= ST_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = sda_oe_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Register read port and transmit shifter.

  // Data is taken one cycle after the request; the slot before the next fall is far longer.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_rd <= '0;
      load_r <= 1'b0;
    end else begin
      o_rd.req <= fetch_go;
      load_r <= o_rd.req;
      if (fetch_go) begin
        o_rd.addr <= ptr_r;
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      tx_sh_r <= 8'h00;
    end else if (load_r) begin
      tx_sh_r <= i_rd_data;
    end else if ((st_r == ST_TXB) & scl_fall) begin
      tx_sh_r <= {tx_sh_r[6:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Ready indication on the interrupt pin.

  // Ready holds the line low until the host first addresses this target.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ready_cnt_r <= 8'(`I2T_READY_CYC);
      ready_r <= 1'b0;
      irq_oe_r <= 1'b0;
    end else begin
      if (ready_cnt_r != 8'h00) begin
        ready_cnt_r <= ready_cnt_r - 8'h01;
        ready_r <= (ready_cnt_r == 8'h01);
      end else if (byte_done & (phase_r == PH_ID) & id_match) begin
        ready_r <= 1'b0;
      end
      irq_oe_r <= ready_r | i_uart_irq;
    end
  end

  assign o_irq_n_o = 1'b0;
  assign o_irq_n_oe = irq_oe_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks.

  AST_ID_ACK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (byte_done && phase_r == PH_ID && id_match && !bus_start && !bus_stop) |=> sda_oe_r)
    else $error("identifier match not acknowledged");

  AST_REG_NACK: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (byte_done && phase_r == PH_REG && !reg_valid) |=> (!sda_oe_r && st_r == ST_ACK))
    else $error("invalid register byte acknowledged");

  AST_MSB_FIRST: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (st_r == ST_TXB && scl_q && !load_r) |-> (sda_oe_r == ~tx_sh_r[7]))
    else $error("transmit bit does not match shifter head");

  AST_BURST_FETCH: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (st_r == ST_MACK && scl_rise && !sda_q && !bus_start && !bus_stop)
    |=> o_rd.req ##1 !o_rd.req ##1 (tx_sh_r == $past(i_rd_data)))
    else $error("host acknowledge did not fetch next byte");

  AST_ACK_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (st_r == ST_ACK && sda_oe_r && scl_q && !bus_start && !bus_stop) |=> sda_oe_r)
    else $error("acknowledge released during clock high");

  AST_NACK_FREE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (st_r == ST_MACK || st_r == ST_IDLE) |-> !sda_oe_r)
    else $error("data line driven in host acknowledge slot");

  AST_READY_IRQ: assert property (@(posedge i_clk_sys)
    $fell(i_rst) |-> ##[READY_LO:READY_HI] o_irq_n_oe)
    else $error("ready not signalled after reset");

  AST_START_DET: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    bus_start |=> (st_r == ST_RXB && phase_r == PH_ID && cnt_r == 4'h0 && !sda_oe_r))
    else $error("start condition not taken");

  AST_PTR_STEP: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    (fetch_go && !byte_done) |=> (ptr_r == (($past(ptr_r) == `I2T_RX_HOLD_ADDR)
        ? $past(ptr_r) : $past(ptr_r) + 8'h01)))
    else $error("burst address step wrong");

endmodule : i2t_target

// ===== test/i2t_host.sv
`timescale 1ns/10ps
module i2t_host #(
  parameter int Q = 6
) (
  input wire logic i_clk_sys,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  int glitches = 0;
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task automatic w(input int n);
    repeat (n) @(negedge i_clk_sys);
  endtask : w
  // Data moves a quarter bit after the clock falls, so both pin filters settle apart.
  task automatic bit_x(input logic b, output logic r);
    w(Q);
    o_sda = b;
    w(Q);
    o_scl = 1'b1;
    w(Q);
    r = i_sda;
    w(Q);
    if (i_sda !== r) glitches++;
    o_scl = 1'b0;
  endtask : bit_x
  task automatic start();
    w(Q);
    o_sda = 1'b1;
    w(Q);
    o_scl = 1'b1;
    w(Q);
    o_sda = 1'b0;
    w(Q);
    o_scl = 1'b0;
  endtask : start
  task automatic stop();
    w(Q);
    o_sda = 1'b0;
    w(Q);
    o_scl = 1'b1;
    w(Q);
    o_sda = 1'b1;
    w(Q);
  endtask : stop
  task automatic send(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], r);
    bit_x(1'b1, r);
    ack = ~r;
  endtask : send
  task automatic recv(input logic ack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(~ack, r);
  endtask : recv
endmodule : i2t_host

// ===== test/tb.sv
`timescale 1ns/10ps
module tb;
  import i2t_pkg::*;
  // Upper identifier bits; the value is arbitrary.
  localparam logic [4:0] ID_HI = 5'h0c;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic scl, sda_h, sda_oe, sda_o, irq_oe, irq_o;
  logic hi_pin = 1'b0;
  logic lo_pin = 1'b0;
  logic uart_irq = 1'b0;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] fifo = 8'h30;
  i2t_rd_req_t rd;
  int failures = 0;
  int n_tests = 0;
  int cyc = 0;
  // Open-drain data line with a pull-up.
  wire logic sda = sda_h & ~sda_oe;
  always #25 clk_sys = ~clk_sys;
  i2t_target #(.TGT_ID_HI(ID_HI)) i2t_target_inst (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_scl(scl), .i_sda(sda),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_addr_select_hi_pin(hi_pin),
    .i_addr_select_lo_pin(lo_pin), .o_rd(rd), .i_rd_data(rd_data),
    .i_uart_irq(uart_irq), .o_irq_n_o(irq_o), .o_irq_n_oe(irq_oe));
  i2t_host i2t_host_inst (.i_clk_sys(clk_sys), .i_sda(sda), .o_scl(scl), .o_sda(sda_h));
  // Address 0x00 pops a new entry per request; others return a fixed pattern.
  always @(negedge clk_sys) begin
    if (rd.req) begin
      rd_data <= (rd.addr == 8'h00) ? fifo : rd.addr ^ 8'ha5;
      if (rd.addr == 8'h00) fifo <= fifo + 8'h01;
    end
    cyc++;
    if (cyc == 40000) begin
      failures++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("[FAIL] %s exp %b got %b", nm, e, g);
    end
  endtask : chk1
  function automatic logic [7:0] id(input logic rw);
    return {ID_HI, hi_pin, lo_pin, rw};
  endfunction : id
  task automatic point(input logic [7:0] a, input logic ok);
    logic k;
    i2t_host_inst.start();
    i2t_host_inst.send(id(1'b0), k);
    chk1("id_w ack", 1'b1, k);
    i2t_host_inst.send(a, k);
    chk1("reg ack", ok, k);
  endtask : point
  task automatic rd_seq(input logic [7:0] a, input int n);
    logic k;
    logic [7:0] d, f0;
    f0 = fifo;
    point(a, 1'b1);
    i2t_host_inst.start();
    i2t_host_inst.send(id(1'b1), k);
    chk1("id_r ack", 1'b1, k);
    for (int i = 0; i < n; i++) begin
      i2t_host_inst.recv(i < n - 1, d);
      chk("data", a == 8'h00 ? f0 + i[7:0] : (a + i[7:0]) ^ 8'ha5, d);
    end
    i2t_host_inst.stop();
  endtask : rd_seq
  task automatic t_ready();
    repeat (19) @(negedge clk_sys);
    chk1("irq early", 1'b0, irq_oe);
    repeat (4) @(negedge clk_sys);
    chk1("irq ready", 1'b1, irq_oe);
    chk1("sda_o", 1'b0, sda_o);
    $display("ready done");
  endtask : t_ready
  task automatic t_reads();
    rd_seq(8'h1f, 1);
    chk1("irq cleared", 1'b0, irq_oe);
    rd_seq(8'h10, 3);
    rd_seq(8'h00, 3);
    $display("reads done");
  endtask : t_reads
  task automatic t_bad();
    logic k;
    point(8'h20, 1'b0);
    i2t_host_inst.stop();
    point(8'hff, 1'b0);
    i2t_host_inst.stop();
    // Write data bytes are outside this read path and must be refused.
    point(8'h01, 1'b1);
    i2t_host_inst.send(8'h5a, k);
    chk1("wdata nack", 1'b0, k);
    i2t_host_inst.stop();
    chk1("released", 1'b0, sda_oe);
    $display("bad register done");
  endtask : t_bad
  task automatic t_pins();
    logic k;
    for (int p = 0; p < 4; p++) begin
      {hi_pin, lo_pin} = p[1:0];
      point(8'h01, 1'b1);
      i2t_host_inst.stop();
    end
    i2t_host_inst.start();
    i2t_host_inst.send(id(1'b0) ^ 8'h80, k);
    chk1("foreign id", 1'b0, k);
    i2t_host_inst.stop();
    $display("identifier done");
  endtask : t_pins
  task automatic t_irq();
    uart_irq = 1'b1;
    repeat (2) @(negedge clk_sys);
    chk1("irq on", 1'b1, irq_oe);
    chk1("irq_o", 1'b0, irq_o);
    uart_irq = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk1("irq off", 1'b0, irq_oe);
    chk("glitches", 8'h00, i2t_host_inst.glitches[7:0]);
    $display("interrupt done");
  endtask : t_irq
  task automatic results();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  initial begin
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    t_ready();
    t_reads();
    t_bad();
    t_pins();
    t_irq();
    results();
  end
endmodule : tb
